// >>> hdl/mec_regs.svh
// constants for the monitor eoc command handler
// assumes inclusion by both ends and by the package user
`ifndef MEC_REGS_SVH
`define MEC_REGS_SVH
`define MEC_CLS_EOC 4'h0
`define MEC_CLS_OVH 4'h2
`define MEC_CLS_LOC 4'h8
`define MEC_CLS_REG 4'hC
`define MEC_ADDR_NT 3'h0
`define MEC_ADDR_BCAST 3'h7
`define MEC_CODE_HOLD 8'h00
`define MEC_CODE_FULL_LOOPBACK_REQUEST 8'h50
`define MEC_CODE_LB1 8'h51
`define MEC_CODE_LB2 8'h52
`define MEC_CODE_RCC 8'h53
`define MEC_CODE_NCC 8'h54
`define MEC_CODE_UTC 8'hAA
`define MEC_CODE_RTN 8'hFF
`define MEC_LOC_FULL_LOOPBACK_REQUEST 8'h50
`endif

// >>> hdl/mec_pkg.sv
// types shared by both ends of the monitor link
// assumes mec_regs.svh is on the include path
package mec_pkg;
   typedef logic [15:0] mec_msg_t;
   typedef enum logic [3:0] {
      MEC_CL_EOC = 4'h1,
      MEC_CL_OVH = 4'h2,
      MEC_CL_LOC = 4'h4,
      MEC_CL_REG = 4'h8
   } mec_class_e;
endpackage

// >>> hdl/mec_if.sv
// monitor channel carrier: one byte per frame, byte handshake each way
// assumes a single clock shared by both ends
interface mec_if;
   // controller to device
   logic [7:0] dn_byte;
   logic dn_valid;
   logic dn_ack;
   // device to controller
   logic [7:0] up_byte;
   logic up_valid;
   logic up_ack;
   modport dev (input dn_byte, input dn_valid, output dn_ack,
                output up_byte, output up_valid, input up_ack);
   modport ctl (output dn_byte, output dn_valid, input dn_ack,
                input up_byte, input up_valid, output up_ack);
endinterface

// >>> hdl/mec_dev.sv
// device end: decodes two-byte monitor messages and runs the eoc interpreter
// assumes the controller end shares clk and keeps one byte in flight
`include "mec_regs.svh"

module mec_dev
   import mec_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // monitor link
   mec_if.dev mon,
   // pending messages from other sources
   input wire logic ovh_req,
   input wire mec_msg_t ovh_msg,
   input wire logic loc_req,
   input wire mec_msg_t loc_msg,
   input wire logic reg_req,
   input wire mec_msg_t reg_msg,
   // forwarded classes
   output logic ovh_rx_stb,
   output logic loc_rx_stb,
   output logic reg_rx_stb,
   output mec_msg_t rx_msg,
   // source handshakes
   output logic ovh_done,
   output logic loc_done,
   output logic reg_done,
   // eoc state
   output logic [7:0] eoc_state,
   output logic loopback_indication_downstream,
   output logic alternate_loopback_indication,
   output logic full_loop_closed,
   output logic first_bearer_loopback,
   output logic second_bearer_loopback,
   output logic crc_invert,
   output logic far_counter_stop,
   output logic near_counter_off,
   output logic errors_hold,
   // downstream status
   input wire logic transparent_auto,
   input wire logic err_or_sync
);
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_HI = 3'b010,
      TX_LO = 3'b100
   } mec_tx_e;

   logic [7:0] hi_r;
   logic have_hi_r;
   logic msg_stb;
   mec_msg_t msg;
   logic eoc_pend_r;
   mec_msg_t eoc_reply_r;
   mec_tx_e tx_r;
   mec_msg_t tx_msg_r;
   logic [3:0] tx_src_r;
   logic ta_q1, ta_q2, es_q1, es_q2;

   // classify a first byte by its leading nibble
   function automatic mec_class_e cls_of(input logic [7:0] b);
      unique case (b[7:4])
         `MEC_CLS_EOC: cls_of = MEC_CL_EOC;
         `MEC_CLS_OVH: cls_of = MEC_CL_OVH;
         `MEC_CLS_REG: cls_of = MEC_CL_REG;
         default: cls_of = MEC_CL_LOC;
      endcase
   endfunction

   // status straps come from outside, so two flops first
   always_ff @(posedge clk) begin
      ta_q1 <= transparent_auto;
      ta_q2 <= ta_q1;
      es_q1 <= err_or_sync;
      es_q2 <= es_q1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         have_hi_r <= 1'b0;
         hi_r <= 8'h00;
      end else if (mon.dn_valid && !mon.dn_ack) begin
         have_hi_r <= !have_hi_r;
         if (!have_hi_r) begin
            hi_r <= mon.dn_byte;
         end
      end
   end

   // ack each byte for one cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mon.dn_ack <= 1'b0;
      end else begin
         mon.dn_ack <= mon.dn_valid && !mon.dn_ack;
      end
   end

   assign msg_stb = mon.dn_valid && !mon.dn_ack && have_hi_r;
   assign msg = {hi_r, mon.dn_byte};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ovh_rx_stb <= 1'b0;
         loc_rx_stb <= 1'b0;
         reg_rx_stb <= 1'b0;
         rx_msg <= 16'h0000;
      end else begin
         ovh_rx_stb <= msg_stb && cls_of(hi_r) == MEC_CL_OVH;
         loc_rx_stb <= msg_stb && cls_of(hi_r) == MEC_CL_LOC;
         reg_rx_stb <= msg_stb && cls_of(hi_r) == MEC_CL_REG;
         if (msg_stb) begin
            rx_msg <= msg;
         end
      end
   end

   // eoc field decode and reply build
   // hold for foreign address or data flag
   // unable to comply on undefined code
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eoc_pend_r <= 1'b0;
         eoc_reply_r <= 16'h0000;
      end else if (msg_stb && cls_of(hi_r) == MEC_CL_EOC) begin
         eoc_pend_r <= 1'b1;
         eoc_reply_r[15:8] <= hi_r;
         if (!((hi_r[3:1] == `MEC_ADDR_NT || hi_r[3:1] == `MEC_ADDR_BCAST) && hi_r[0])) begin
            eoc_reply_r[7:0] <= `MEC_CODE_HOLD;
         end else begin
            unique case (mon.dn_byte)
               `MEC_CODE_HOLD, `MEC_CODE_FULL_LOOPBACK_REQUEST, `MEC_CODE_LB1, `MEC_CODE_LB2, `MEC_CODE_RCC,
               `MEC_CODE_NCC, `MEC_CODE_RTN, `MEC_CODE_UTC: eoc_reply_r[7:0] <= mon.dn_byte;
               default: eoc_reply_r[7:0] <= `MEC_CODE_UTC;
            endcase
         end
      end else if (tx_r == TX_IDLE && !reg_req && eoc_pend_r) begin
         eoc_pend_r <= 1'b0; // taken by transmitter
      end
   end

   // commands only change eoc state registers
   // release all, state back to ff
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eoc_state <= `MEC_CODE_RTN;
         loopback_indication_downstream <= 1'b0;
         alternate_loopback_indication <= 1'b0;
         first_bearer_loopback <= 1'b0;
         second_bearer_loopback <= 1'b0;
         crc_invert <= 1'b0;
         far_counter_stop <= 1'b0;
         near_counter_off <= 1'b0;
         errors_hold <= 1'b0;
      end else if (msg_stb && cls_of(hi_r) == MEC_CL_EOC && hi_r[0] &&
                   (hi_r[3:1] == `MEC_ADDR_NT || hi_r[3:1] == `MEC_ADDR_BCAST)) begin
         unique case (mon.dn_byte)
            `MEC_CODE_FULL_LOOPBACK_REQUEST: begin
               eoc_state <= mon.dn_byte;
               loopback_indication_downstream <= ta_q2;
               alternate_loopback_indication <= es_q2;
            end
            `MEC_CODE_LB1: begin
               eoc_state <= mon.dn_byte;
               first_bearer_loopback <= 1'b1;
            end
            `MEC_CODE_LB2: begin
               eoc_state <= mon.dn_byte;
               second_bearer_loopback <= 1'b1;
            end
            `MEC_CODE_RCC: begin
               eoc_state <= mon.dn_byte;
               crc_invert <= 1'b1;
               far_counter_stop <= 1'b1;
               errors_hold <= 1'b1;
            end
            `MEC_CODE_NCC: begin
               eoc_state <= mon.dn_byte;
               near_counter_off <= 1'b1;
               errors_hold <= 1'b1;
            end
            `MEC_CODE_RTN: begin
               eoc_state <= `MEC_CODE_RTN;
               loopback_indication_downstream <= 1'b0;
               alternate_loopback_indication <= 1'b0;
               first_bearer_loopback <= 1'b0;
               second_bearer_loopback <= 1'b0;
               crc_invert <= 1'b0;
               far_counter_stop <= 1'b0;
               near_counter_off <= 1'b0;
               errors_hold <= 1'b0;
            end
            default: ; // hold and others leave state alone
         endcase
      end
   end

   // local full loopback closes the inner loop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         full_loop_closed <= 1'b0;
      end else if (msg_stb && cls_of(hi_r) == MEC_CL_EOC && hi_r[0] && mon.dn_byte == `MEC_CODE_RTN &&
                   (hi_r[3:1] == `MEC_ADDR_NT || hi_r[3:1] == `MEC_ADDR_BCAST)) begin
         full_loop_closed <= 1'b0;
      end else if (msg_stb && cls_of(hi_r) == MEC_CL_LOC && mon.dn_byte == `MEC_LOC_FULL_LOOPBACK_REQUEST &&
                   eoc_state == `MEC_CODE_FULL_LOOPBACK_REQUEST) begin
         full_loop_closed <= 1'b1;
      end
   end

   // confirmations leave on the upstream byte lane
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_r <= TX_IDLE;
         tx_msg_r <= 16'h0000;
         tx_src_r <= 4'h0;
         mon.up_valid <= 1'b0;
         mon.up_byte <= 8'h00;
         ovh_done <= 1'b0;
         loc_done <= 1'b0;
         reg_done <= 1'b0;
      end else begin
         ovh_done <= 1'b0;
         loc_done <= 1'b0;
         reg_done <= 1'b0;
         unique case (tx_r)
            TX_IDLE: begin
               if (reg_req || eoc_pend_r || ovh_req || loc_req) begin
                  tx_msg_r <= reg_req ? reg_msg : eoc_pend_r ? eoc_reply_r : ovh_req ? ovh_msg : loc_msg;
                  tx_src_r <= reg_req ? 4'h8 : eoc_pend_r ? 4'h1 : ovh_req ? 4'h2 : 4'h4;
                  mon.up_byte <= reg_req ? reg_msg[15:8] : eoc_pend_r ? eoc_reply_r[15:8] :
                                 ovh_req ? ovh_msg[15:8] : loc_msg[15:8];
                  mon.up_valid <= 1'b1;
                  tx_r <= TX_HI;
               end
            end
            TX_HI: begin
               if (mon.up_ack) begin
                  mon.up_byte <= tx_msg_r[7:0];
                  tx_r <= TX_LO;
               end
            end
            TX_LO: begin
               if (mon.up_ack) begin
                  mon.up_valid <= 1'b0;
                  reg_done <= tx_src_r[3];
                  ovh_done <= tx_src_r[1];
                  loc_done <= tx_src_r[2];
                  tx_r <= TX_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// >>> hdl/mec_ctl.sv
// controller end: sends two-byte commands once, collects replies
// assumes the device end shares clk
`include "mec_regs.svh"

module mec_ctl
   import mec_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // monitor link
   mec_if.ctl mon,
   // user command side
   input wire logic cmd_valid,
   input wire mec_msg_t cmd_msg,
   output logic cmd_ready,
   // user reply side
   output logic rsp_valid,
   output mec_msg_t rsp_msg
);
   typedef enum logic [2:0] {
      CS_IDLE = 3'b001,
      CS_HI = 3'b010,
      CS_LO = 3'b100
   } mec_cs_e;

   mec_cs_e cs_r;
   mec_msg_t out_r;
   logic [7:0] rhi_r;
   logic rhave_r;

   // each command sent once, whole message
   // next message waits for the last ack
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_r <= CS_IDLE;
         out_r <= 16'h0000;
         mon.dn_valid <= 1'b0;
         mon.dn_byte <= 8'h00;
         cmd_ready <= 1'b1;
      end else begin
         unique case (cs_r)
            CS_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  out_r <= cmd_msg;
                  mon.dn_byte <= cmd_msg[15:8];
                  mon.dn_valid <= 1'b1;
                  cmd_ready <= 1'b0;
                  cs_r <= CS_HI;
               end
            end
            CS_HI: begin
               if (mon.dn_ack) begin
                  mon.dn_valid <= 1'b0; // drop for one cycle between bytes
                  cs_r <= CS_LO;
               end
            end
            CS_LO: begin
               if (!mon.dn_valid && !mon.dn_ack) begin
                  mon.dn_byte <= out_r[7:0];
                  mon.dn_valid <= 1'b1;
               end else if (mon.dn_valid && mon.dn_ack) begin
                  mon.dn_valid <= 1'b0;
                  cmd_ready <= 1'b1;
                  cs_r <= CS_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mon.up_ack <= 1'b0;
         rhi_r <= 8'h00;
         rhave_r <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_msg <= 16'h0000;
      end else begin
         mon.up_ack <= mon.up_valid && !mon.up_ack;
         rsp_valid <= 1'b0;
         if (mon.up_valid && !mon.up_ack) begin
            rhave_r <= !rhave_r;
            if (!rhave_r) begin
               rhi_r <= mon.up_byte;
            end else begin
               rsp_msg <= {rhi_r, mon.up_byte};
               rsp_valid <= 1'b1;
            end
         end
      end
   end
endmodule

// >>> sim/mec_sva.sv
// assertions on the monitor link between the controller and device ends
// assumes one clock and a synchronous active-low reset shared by both ends
module mec_sva (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // downstream bytes
   input wire logic [7:0] dn_byte,
   input wire logic dn_valid,
   input wire logic dn_ack,
   // upstream bytes
   input wire logic [7:0] up_byte,
   input wire logic up_valid,
   input wire logic up_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic dn_odd_r;
   // byte parity of the downstream pair, so the second byte can be awaited
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dn_odd_r <= 1'h0;
      end else if (dn_ack) begin
         dn_odd_r <= ~dn_odd_r;
      end
   end
   // downstream handshake
   property p_dn_take;
      dn_valid && !dn_ack |=> dn_ack;
   endproperty
   a_dn_take: assert property (p_dn_take) else $error("downstream byte not acked");
   property p_dn_pulse;
      dn_ack |=> !dn_ack;
   endproperty
   a_dn_pulse: assert property (p_dn_pulse) else $error("downstream ack too long");
   property p_dn_drop;
      dn_ack |=> !dn_valid;
   endproperty
   a_dn_drop: assert property (p_dn_drop) else $error("byte offered again after ack");
   property p_dn_hold;
      dn_valid && !dn_ack |=> $stable(dn_byte);
   endproperty
   a_dn_hold: assert property (p_dn_hold) else $error("downstream byte moved");
   property p_dn_pair;
      dn_ack && !dn_odd_r |-> ##[2:4] dn_valid;
   endproperty
   a_dn_pair: assert property (p_dn_pair) else $error("second byte missing");
   // upstream handshake
   property p_up_cause;
      up_ack |-> $past(up_valid);
   endproperty
   a_up_cause: assert property (p_up_cause) else $error("upstream ack without byte");
   property p_up_walk;
      $rose(up_valid) |=> up_ack ##2 up_ack ##1 !up_valid;
   endproperty
   a_up_walk: assert property (p_up_walk) else $error("upstream message not two bytes");
   property p_up_hold;
      up_valid && !up_ack |=> $stable(up_byte);
   endproperty
   a_up_hold: assert property (p_up_hold) else $error("upstream byte moved");
   // main traffic seen
   c_dn_msg: cover property (dn_ack && dn_odd_r);
   c_up_msg: cover property ($fell(up_valid));
   c_up_eoc: cover property ($rose(up_valid) && up_byte[7:4] == 4'h0);
endmodule

// >>> sim/monitor_eoc_command_handler_test.sv
// bench for the monitor eoc command handler: both ends joined back to back
// assumes mec_pkg, mec_if, both ends and mec_sva are compiled first
`include "mec_regs.svh"
module monitor_eoc_command_handler_test
   import mec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic cmd_valid = 1'h0;
   logic transparent_auto = 1'h1;
   logic err_or_sync = 1'h0;
   logic [2:0] src_req = 3'h0;
   mec_msg_t cmd_msg = 16'h0000;
   mec_msg_t src_msg [3] = '{16'h0000, 16'h0000, 16'h0000};
   logic cmd_ready, rsp_valid, ovh_rx_stb, loc_rx_stb, reg_rx_stb, ok;
   logic [2:0] src_done;
   logic [8:0] flags;
   logic [8:0] exp_f = 9'h000;
   logic [7:0] eoc_state;
   logic [7:0] exp_st = 8'hFF;
   logic [18:0] e;
   mec_msg_t rsp_msg, rx_msg;
   mec_msg_t rspq [$];
   logic [18:0] rxq [$];
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   mec_if mon ();
   mec_ctl mec_ctl_inst (.clk(clk), .rst_n(rst_n), .mon(mon), .cmd_valid(cmd_valid), .cmd_msg(cmd_msg),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_msg(rsp_msg));
   mec_dev mec_dev_inst (.clk(clk), .rst_n(rst_n), .mon(mon), .ovh_req(src_req[1]), .ovh_msg(src_msg[1]),
      .loc_req(src_req[0]), .loc_msg(src_msg[0]), .reg_req(src_req[2]), .reg_msg(src_msg[2]),
      .ovh_rx_stb(ovh_rx_stb), .loc_rx_stb(loc_rx_stb), .reg_rx_stb(reg_rx_stb), .rx_msg(rx_msg),
      .ovh_done(src_done[1]), .loc_done(src_done[0]), .reg_done(src_done[2]), .eoc_state(eoc_state),
      .loopback_indication_downstream(flags[8]), .alternate_loopback_indication(flags[7]),
      .full_loop_closed(flags[6]), .first_bearer_loopback(flags[5]), .second_bearer_loopback(flags[4]),
      .crc_invert(flags[3]), .far_counter_stop(flags[2]), .near_counter_off(flags[1]), .errors_hold(flags[0]),
      .transparent_auto(transparent_auto), .err_or_sync(err_or_sync));
   mec_sva mec_sva_inst (.clk(clk), .rst_n(rst_n), .dn_byte(mon.dn_byte), .dn_valid(mon.dn_valid),
      .dn_ack(mon.dn_ack), .up_byte(mon.up_byte), .up_valid(mon.up_valid), .up_ack(mon.up_ack));
   // 50 MHz clock
   always #10 clk = ~clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one controller command, released as soon as it is taken
   task automatic send(input mec_msg_t m);
      int n;
      n = 0;
      while (cmd_ready !== 1'h1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmd_msg = m;
      cmd_valid = 1'h1;
      @(posedge clk);
      #1;
      cmd_valid = 1'h0;
   endtask
   // a reply that never arrives stays queued and fails here
   task automatic settle();
      int n;
      n = 0;
      while (rspq.size() + rxq.size() > 0 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      repeat (4) @(posedge clk);
      #1;
      check({7'h00, flags}, {7'h00, exp_f});
      check(16'(rspq.size() + rxq.size()), 16'h0000);
   endtask
   // reply and state model of the eoc interpreter
   task automatic expect_eoc(input logic [2:0] a, input logic dm, input logic [7:0] c);
      logic [7:0] rc;
      ok = (a == `MEC_ADDR_NT || a == `MEC_ADDR_BCAST) && dm;
      rc = (c inside {8'h00, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'hAA, 8'hFF}) ? c : `MEC_CODE_UTC;
      rspq.push_back({`MEC_CLS_EOC, a, dm, ok ? rc : `MEC_CODE_HOLD});
      if (ok && (c inside {8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'hFF})) begin
         exp_st = c;
      end
      if (ok) begin
         case (c)
            `MEC_CODE_FULL_LOOPBACK_REQUEST: exp_f[8:7] = {transparent_auto, err_or_sync};
            `MEC_CODE_LB1: exp_f[5] = 1'h1;
            `MEC_CODE_LB2: exp_f[4] = 1'h1;
            `MEC_CODE_RCC: exp_f = exp_f | 9'h00D;
            `MEC_CODE_NCC: exp_f = exp_f | 9'h003;
            `MEC_CODE_RTN: exp_f = 9'h000;
            default: exp_f = exp_f;
         endcase
      end
   endtask
   task automatic send_eoc(input logic [2:0] a, input logic dm, input logic [7:0] c);
      expect_eoc(a, dm, c);
      send({`MEC_CLS_EOC, a, dm, c});
      settle();
      if (ok && (c inside {8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'hFF})) begin
         check({8'h00, eoc_state}, {8'h00, exp_st});
      end
   endtask
   // other classes downstream are forwarded, stb order ovh, loc, reg
   task automatic send_rx(input logic [2:0] s, input mec_msg_t m);
      rxq.push_back({s, m});
      if (s == 3'h2 && m[7:0] == `MEC_LOC_FULL_LOOPBACK_REQUEST && exp_st == `MEC_CODE_FULL_LOOPBACK_REQUEST) begin
         exp_f[6] = 1'h1;
      end
      send(m);
      settle();
   endtask
   // a source holds its request across reps messages
   task automatic serve(input int k, input mec_msg_t m, input int reps);
      int n;
      n = 0;
      src_msg[k] = m;
      src_req[k] = 1'h1;
      for (int i = 1; i <= reps; i++) begin
         while (src_done[k] !== 1'h1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
         end
         src_msg[k] = m + 16'(i);
         if (i == reps) begin
            src_req[k] = 1'h0;
         end
         @(posedge clk);
         #1;
      end
   endtask
   // result watcher: oldest note against each reply and forwarded message
   always @(posedge clk) begin
      if (rsp_valid === 1'h1) begin
         if (rspq.size() == 0) begin
            check(rsp_msg, ~rsp_msg);
         end else begin
            check(rsp_msg, rspq.pop_front());
         end
      end
      if ((ovh_rx_stb | loc_rx_stb | reg_rx_stb) === 1'h1) begin
         e = (rxq.size() == 0) ? 19'h7FFFF : rxq.pop_front();
         check(rx_msg, e[15:0]);
         check({13'h0000, ovh_rx_stb, loc_rx_stb, reg_rx_stb}, {13'h0000, e[18:16]});
      end
   end
   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         $display("ERROR at %0t: timeout", $time);
         end_of_test();
      end
   end
   initial begin
      logic [7:0] codes [6];
      mec_msg_t mr, mo, ml;
      codes = '{8'h51, 8'h52, 8'h53, 8'h54, 8'hAA, 8'hFF};
      void'($urandom(32'h369998AA));
      repeat (16) @(posedge clk);
      #1;
      check({8'h00, eoc_state}, 16'h00FF);
      check({7'h00, flags}, 16'h0000);
      check({15'h0000, cmd_ready}, 16'h0001);
      rst_n = 1'h1;
      @(posedge clk);
      #1;
      send_eoc(3'h0, 1'h1, 8'h00);
      send_eoc(3'h0, 1'h1, 8'h50);
      send_rx(3'h2, {8'h80, `MEC_LOC_FULL_LOOPBACK_REQUEST});
      foreach (codes[i]) begin
         send_eoc(3'h0, 1'h1, codes[i]);
      end
      send_eoc(3'h0, 1'h1, 8'($urandom_range(1, 79)));
      send_eoc(3'h7, 1'h1, 8'($urandom_range(1, 79)));
      send_eoc(3'($urandom_range(1, 6)), 1'h1, 8'h51);
      send_eoc(3'h0, 1'h0, 8'h53);
      send_eoc(3'h7, 1'h1, 8'h53);
      send_eoc(3'h7, 1'h1, 8'hFF);
      transparent_auto = 1'h0;
      err_or_sync = 1'h1;
      send_eoc(3'h0, 1'h1, 8'h50);
      send_eoc(3'h0, 1'h1, 8'hFF);
      send_rx(3'h4, {4'h2, 12'($urandom)});
      send_rx(3'h1, {4'hC, 12'($urandom)});
      // register, eoc reply, overhead, local all pending together
      mr = {4'hC, 11'($urandom), 1'h0};
      mo = {4'h2, 12'($urandom)};
      ml = {4'h8, 12'($urandom)};
      rspq.push_back(mr);
      rspq.push_back(mr + 16'h0001);
      expect_eoc(3'h0, 1'h1, 8'h52);
      rspq.push_back(mo);
      rspq.push_back(ml);
      fork
         serve(2, mr, 2);
         serve(1, mo, 1);
         serve(0, ml, 1);
         send({8'h01, 8'h52});
      join
      settle();
      end_of_test();
   end
endmodule
